/* File: inc/lcd_reset_defs.svh */
// Offsets, field positions, reset values and timing counts of the LCD reset block
// What this block does
// - Hard reset: display off, normal, segments normal
// - Hard reset clears the three power bits
// - Hard reset empties the serial shift register
// - Hard reset clears all-points and power saver
// - Both resets leave read-modify-write mode
// - Both resets clear the static indicator bits
// - Both resets zero start line, column, page
// - Both resets: normal row scan, ratio mode off
// - Both resets: volume mode off, volume 100000b, test off
// - Soft reset touches only the shared defaults
// - Regulator resistors connected only while clear or reset_n low
// - Clear low stops timing, outputs held high
// - Clear leaves the data bus pins alone
// - Drivers show VDD in clear, idle after
// - Status shows reset and busy; commands refused
`ifndef LCD_RESET_DEFS_SVH
`define LCD_RESET_DEFS_SVH

`define OFS_CTRL 6'h00
`define OFS_POWER 6'h04
`define OFS_ADDR 6'h08
`define OFS_VOLUME 6'h0c
`define OFS_SERIAL 6'h10
`define OFS_STATUS 6'h14
`define OFS_DATA 6'h18

`define CTRL_DISP_ON 0
`define CTRL_INVERT 1
`define CTRL_SEG_REVERSE 2
`define CTRL_ALL_POINTS 3
`define CTRL_ROW_REVERSE 4
`define CTRL_RMW 5
`define CTRL_TEST 6
`define CTRL_SOFT_RESET 31

`define ADDR_START_LSB 0
`define ADDR_PAGE_LSB 8
`define ADDR_COLUMN_LSB 16
`define VOL_VOLUME_LSB 0
`define VOL_VOLUME_MODE 8
`define VOL_RATIO_MODE 9
`define VOL_STATIC_LSB 16
`define SER_COUNT_LSB 8
`define SER_BYTE_LSB 16

`define ST_BUSY_BIT 7
`define ST_SEG_BIT 6
`define ST_OFF_BIT 5
`define ST_RESET_BIT 4
`define ST_SAVER_BIT 8

`define VOLUME_DEFAULT 6'h20
`define COLUMN_LAST 8'h83

`define CLK_PERIOD_NS 4
`define RESET_BUSY_NS 40
`define RESET_BUSY_CYC ((`RESET_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINE_DIV_CYC 250
`define FRAME_LINES 65

`endif

/* File: inc/lcd_reset_pkg.sv */
// Types shared by the LCD reset block
package lcd_reset_pkg;
  typedef enum logic [1:0] {LEVEL_VDD, LEVEL_IDLE} driveLevel_t;
  typedef enum logic {SEQ_BUSY, SEQ_RUN} seqState_t;
endpackage : lcd_reset_pkg

/* File: rtl/lcd_reset_defaults.sv */
// Reset defaults, status, timing outputs and AXI4-Lite registers of the LCD driver
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "lcd_reset_defs.svh"
module lcd_reset_defaults import lcd_reset_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chipClear_n,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic rowShiftPulse,
  output logic alternationPolarity,
  output logic staticIndicatorDrive,
  output logic blankingOutput_n,
  output driveLevel_t columnDriverOutputs,
  output driveLevel_t rowDriverOutputs,
  output logic regResistorOn
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset domains
  // Device state follows the clear pin at once and for as long as it is low;
  // the bus keeps running so software can watch the reset flag.
  wire devReset_n = reset_n & chipClear_n;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake state
  logic awHeld_r, wHeld_r;
  logic [5:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;

  // Device state
  logic dispOn_r, invert_r, segReverse_r, allPoints_r, saver_r;
  logic [2:0] power_r;
  logic rowReverse_r, rmw_r, test_r, ratioMode_r, volumeMode_r;
  logic [1:0] static_r;
  logic [5:0] volume_r, startLine_r;
  logic [3:0] page_r;
  logic [7:0] column_r;
  logic [7:0] shift_r, serByte_r;
  logic [2:0] serCount_r;
  seqState_t seq_r;
  logic [3:0] busyCnt_r;
  logic [7:0] lineCnt_r;
  logic [6:0] lineIdx_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read-back words
  wire busy = (seq_r == SEQ_BUSY);
  wire [31:0] ctrlWord = {25'h0, test_r, rmw_r, rowReverse_r, allPoints_r, segReverse_r, invert_r, dispOn_r};
  wire [31:0] powerWord = {29'h0, power_r};
  wire [31:0] addrWord = {8'h00, column_r, 4'h0, page_r, 2'h0, startLine_r};
  wire [31:0] volumeWord = {14'h0, static_r, 6'h0, ratioMode_r, volumeMode_r, 2'h0, volume_r};
  wire [31:0] serialWord = {8'h00, serByte_r, 5'h00, serCount_r, shift_r};
  wire [31:0] statusWord = {23'h0, saver_r, busy, ~segReverse_r, ~dispOn_r, busy, 4'h0};
  wire [31:0] dataWord = {24'h0, column_r};

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  // Low address bits are dropped; each register is one aligned word
  wire wrFire = awHeld_r & wHeld_r & ~bvalid;
  wire [31:0] laneMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire wrCtrl = (awAddr_r == `OFS_CTRL);
  wire wrPower = (awAddr_r == `OFS_POWER);
  wire wrAddr = (awAddr_r == `OFS_ADDR);
  wire wrVolume = (awAddr_r == `OFS_VOLUME);
  wire wrSerial = (awAddr_r == `OFS_SERIAL);
  wire wrData = (awAddr_r == `OFS_DATA);
  wire wrMapped = wrCtrl | wrPower | wrAddr | wrVolume | wrSerial | wrData | (awAddr_r == `OFS_STATUS);
  // Commands are dropped while busy; the bus still answers so the host never hangs
  wire cmdOk = wrFire & ~busy;
  wire [31:0] ctrlNew = (ctrlWord & ~laneMask) | (wData_r & laneMask);
  wire [31:0] powerNew = (powerWord & ~laneMask) | (wData_r & laneMask);
  wire [31:0] addrNew = (addrWord & ~laneMask) | (wData_r & laneMask);
  wire [31:0] volumeNew = (volumeWord & ~laneMask) | (wData_r & laneMask);
  wire ctrlWe = cmdOk & wrCtrl;
  wire softReset = ctrlWe & ctrlNew[`CTRL_SOFT_RESET];
  wire powerWe = cmdOk & wrPower;
  wire addrWe = cmdOk & wrAddr;
  wire volumeWe = cmdOk & wrVolume;
  wire serialWe = cmdOk & wrSerial & wStrb_r[0];
  wire dataWe = cmdOk & wrData;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  wire arFire = arvalid & arready;
  wire [31:0] rdSel = (araddr == `OFS_CTRL) ? ctrlWord :
                      (araddr == `OFS_POWER) ? powerWord :
                      (araddr == `OFS_ADDR) ? addrWord :
                      (araddr == `OFS_VOLUME) ? volumeWord :
                      (araddr == `OFS_SERIAL) ? serialWord :
                      (araddr == `OFS_STATUS) ? statusWord :
                      (araddr == `OFS_DATA) ? dataWord : 32'h0;
  wire rdMapped = (araddr == `OFS_CTRL) | (araddr == `OFS_POWER) | (araddr == `OFS_ADDR) |
                  (araddr == `OFS_VOLUME) | (araddr == `OFS_SERIAL) | (araddr == `OFS_STATUS) |
                  (araddr == `OFS_DATA);
  // A data read advances the column only outside read-modify-write
  wire dataRd = arFire & (araddr == `OFS_DATA) & ~busy & ~rmw_r;

  ////////////////////////////////////////////////////////////////////////////
  // Column auto-increment, stops at the last column
  // Capping rather than wrapping keeps a long burst off column zero
  wire colStep = dataWe | dataRd;
  wire [7:0] columnInc = (column_r == `COLUMN_LAST) ? column_r : column_r + 8'h01;
  wire [7:0] column_nxt = softReset ? 8'h00 :
                          addrWe ? addrNew[`ADDR_COLUMN_LSB +: 8] :
                          colStep ? columnInc : column_r;

  // Display off while all points lit enters the power saver
  wire dispOnNew = ctrlNew[`CTRL_DISP_ON];
  wire allNew = ctrlNew[`CTRL_ALL_POINTS];
  wire saver_nxt = ctrlWe ? (~dispOnNew & allNew) : saver_r;

  // Serial bits arrive D7 first
  wire [7:0] shiftIn = {shift_r[6:0], wData_r[0]};
  wire serFull = (serCount_r == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Busy sequencer after either reset
  // Commands are held off until the defaults have settled
  logic seqDone;
  assign seqDone = (busyCnt_r == 4'(`RESET_BUSY_CYC - 1));
  seqState_t seq_nxt;
  always_comb begin
    case (seq_r)
      SEQ_BUSY: seq_nxt = seqDone ? SEQ_RUN : SEQ_BUSY;
      SEQ_RUN: seq_nxt = softReset ? SEQ_BUSY : SEQ_RUN;
      default: seq_nxt = SEQ_BUSY;
    endcase
  end

  always_ff @(posedge clk or negedge devReset_n) begin
    if (!devReset_n) begin
      seq_r <= SEQ_BUSY;
      busyCnt_r <= 4'h0;
    end else begin
      seq_r <= seq_nxt;
      busyCnt_r <= (seq_r == SEQ_BUSY && !seqDone) ? busyCnt_r + 4'h1 : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Items kept by the soft reset
  always_ff @(posedge clk or negedge devReset_n) begin
    if (!devReset_n) begin
      dispOn_r <= 1'b0;
      invert_r <= 1'b0;
      segReverse_r <= 1'b0;
      allPoints_r <= 1'b0;
      saver_r <= 1'b0;
      power_r <= 3'h0;
    end else if (ctrlWe) begin
      // The soft reset bit shares this write but leaves these fields as written
      dispOn_r <= dispOnNew;
      invert_r <= ctrlNew[`CTRL_INVERT];
      segReverse_r <= ctrlNew[`CTRL_SEG_REVERSE];
      allPoints_r <= allNew;
      saver_r <= saver_nxt;
    end else if (powerWe) begin
      power_r <= powerNew[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Items shared by both resets
  always_ff @(posedge clk or negedge devReset_n) begin
    if (!devReset_n) begin
      rmw_r <= 1'b0;
      static_r <= 2'h0;
      startLine_r <= 6'h00;
      page_r <= 4'h0;
      rowReverse_r <= 1'b0;
      ratioMode_r <= 1'b0;
      volumeMode_r <= 1'b0;
      volume_r <= `VOLUME_DEFAULT;
      test_r <= 1'b0;
    end else if (softReset) begin
      rmw_r <= 1'b0;
      static_r <= 2'h0;
      startLine_r <= 6'h00;
      page_r <= 4'h0;
      rowReverse_r <= 1'b0;
      ratioMode_r <= 1'b0;
      volumeMode_r <= 1'b0;
      volume_r <= `VOLUME_DEFAULT;
      test_r <= 1'b0;
    end else begin
      if (ctrlWe) begin
        rmw_r <= ctrlNew[`CTRL_RMW];
        rowReverse_r <= ctrlNew[`CTRL_ROW_REVERSE];
        test_r <= ctrlNew[`CTRL_TEST];
      end
      if (addrWe) begin
        startLine_r <= addrNew[`ADDR_START_LSB +: 6];
        page_r <= addrNew[`ADDR_PAGE_LSB +: 4];
      end
      if (volumeWe) begin
        volume_r <= volumeNew[`VOL_VOLUME_LSB +: 6];
        volumeMode_r <= volumeNew[`VOL_VOLUME_MODE];
        ratioMode_r <= volumeNew[`VOL_RATIO_MODE];
        static_r <= volumeNew[`VOL_STATIC_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk or negedge devReset_n) begin
    if (!devReset_n) begin
      column_r <= 8'h00;
    end else begin
      column_r <= column_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift register, cleared only by the clear pin or reset_n
  // A full byte is copied out and the shift register starts over
  always_ff @(posedge clk or negedge devReset_n) begin
    if (!devReset_n) begin
      shift_r <= 8'h00;
      serCount_r <= 3'h0;
      serByte_r <= 8'h00;
    end else if (serialWe) begin
      shift_r <= serFull ? 8'h00 : shiftIn;
      serCount_r <= serCount_r + 3'h1;
      if (serFull) begin
        serByte_r <= shiftIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display timing; clear stops the divider and pins the outputs high
  // Frame polarity flips once per frame of row pulses
  wire lineTick = (lineCnt_r == 8'(`LINE_DIV_CYC - 1));
  wire frameEnd = lineTick & (lineIdx_r == 7'(`FRAME_LINES - 1));
  wire staticBlink = static_r[1] ? alternationPolarity : 1'b1;

  always_ff @(posedge clk or negedge devReset_n) begin
    if (!devReset_n) begin
      lineCnt_r <= 8'h00;
      lineIdx_r <= 7'h00;
      rowShiftPulse <= 1'b1;
      alternationPolarity <= 1'b1;
      staticIndicatorDrive <= 1'b1;
      blankingOutput_n <= 1'b1;
    end else begin
      lineCnt_r <= lineTick ? 8'h00 : lineCnt_r + 8'h01;
      lineIdx_r <= frameEnd ? 7'h00 : (lineTick ? lineIdx_r + 7'h01 : lineIdx_r);
      rowShiftPulse <= lineTick;
      alternationPolarity <= frameEnd ? ~alternationPolarity : alternationPolarity;
      staticIndicatorDrive <= static_r[0] & staticBlink;
      blankingOutput_n <= dispOn_r;
    end
  end

  // Analog controls
  // No data bus pin is driven from this block, so clear leaves it alone
  always_ff @(posedge clk or negedge devReset_n) begin
    if (!devReset_n) begin
      columnDriverOutputs <= LEVEL_VDD;
      rowDriverOutputs <= LEVEL_VDD;
      regResistorOn <= 1'b1;
    end else begin
      columnDriverOutputs <= LEVEL_IDLE;
      rowDriverOutputs <= LEVEL_IDLE;
      regResistorOn <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels
  // Address and data may come in either order; the answer waits for both
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 6'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid & awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {awaddr[5:2], 2'h0};
      end else if (wrFire) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid & wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (wrFire) begin
        wHeld_r <= 1'b0;
      end
      awready <= ~awHeld_r & ~(awvalid & awready) & ~bvalid;
      wready <= ~wHeld_r & ~(wvalid & wready) & ~bvalid;
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp <= wrMapped ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  // Read data is captured on the accepting edge and held until taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      arready <= ~rvalid & ~arFire;
      if (arFire) begin
        rvalid <= 1'b1;
        rdata <= rdSel;
        rresp <= rdMapped ? 2'h0 : 2'h2;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule : lcd_reset_defaults

/* File: tb/lcd_reset_defaults_sva.sv */
// Concurrent checks on the LCD reset defaults block
`timescale 1ns/1ns
module lcd_reset_defaults_sva import lcd_reset_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chipClear_n,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rowShiftPulse,
  input wire logic alternationPolarity,
  input wire logic staticIndicatorDrive,
  input wire logic blankingOutput_n,
  input wire driveLevel_t columnDriverOutputs,
  input wire driveLevel_t rowDriverOutputs,
  input wire logic regResistorOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  property p_clrOut;
    !chipClear_n |-> rowShiftPulse && alternationPolarity && staticIndicatorDrive && blankingOutput_n;
  endproperty
  a_clrOut: assert property (p_clrOut) else $error("timing pins low in clear");
  property p_clrDrv;
    !chipClear_n |-> columnDriverOutputs == LEVEL_VDD && rowDriverOutputs == LEVEL_VDD;
  endproperty
  a_clrDrv: assert property (p_clrDrv) else $error("drivers not at supply in clear");
  property p_clrRes; !chipClear_n |-> regResistorOn; endproperty
  a_clrRes: assert property (p_clrRes) else $error("resistor open in clear");
  // The first edge after release must already show run values
  property p_relOut;
    $rose(chipClear_n) |=> !regResistorOn && !rowShiftPulse && columnDriverOutputs == LEVEL_IDLE
      && rowDriverOutputs == LEVEL_IDLE;
  endproperty
  a_relOut: assert property (p_relOut) else $error("no run values after release");
  property p_bAns; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
  a_bAns: assert property (p_bAns) else $error("write answer late");
  property p_rAns; arvalid && arready |=> rvalid; endproperty
  a_rAns: assert property (p_rAns) else $error("read answer late");
  property p_bDone; bvalid && bready |=> !bvalid; endproperty
  a_bDone: assert property (p_bDone) else $error("write answer repeated");
  property p_rDone; rvalid && rready |=> !rvalid; endproperty
  a_rDone: assert property (p_rDone) else $error("read answer repeated");
  property p_wRef; bvalid |-> !awready && !wready; endproperty
  a_wRef: assert property (p_wRef) else $error("write taken while answering");
  property p_rRef; rvalid |-> !arready; endproperty
  a_rRef: assert property (p_rRef) else $error("read taken while answering");
  ////////////////////////////////////////////////////////////
  c_release: cover property (!chipClear_n ##1 chipClear_n);
  c_slvErr: cover property (bvalid && bready && bresp == 2'h2);
  c_read: cover property (rvalid && rready);
endmodule : lcd_reset_defaults_sva

bind lcd_reset_defaults lcd_reset_defaults_sva lcd_reset_defaults_sva_inst (.clk, .reset_n, .chipClear_n,
  .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rowShiftPulse, .alternationPolarity,
  .staticIndicatorDrive, .blankingOutput_n, .columnDriverOutputs, .rowDriverOutputs, .regResistorOn);

/* File: tb/lcd_host_model.sv */
// Host side model that drives the hardware clear pin
`timescale 1ns/1ns
module lcd_host_model (
  input wire logic clk,
  input wire logic holdClear,
  output logic chipClear_n
);
  // Low from power-up so the device starts from defaults
  initial chipClear_n = 1'b0;
  // Pin only moves on a clock edge; kept high otherwise, as an external supply needs
  always @(posedge clk) chipClear_n <= !holdClear;
endmodule : lcd_host_model

/* File: tb/lcd_reset_defaults_test.sv */
// Self-checking bench for the LCD reset defaults block
`timescale 1ns/1ns
`include "lcd_reset_defs.svh"
module lcd_reset_defaults_test import lcd_reset_pkg::*;;
  typedef struct {logic [33:0] e; logic [33:0] m;} note_t;
  logic clk = 1'b0, reset_n = 1'b0, holdClear = 1'b1, chipClear_n;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, regResistorOn;
  logic rowShiftPulse, alternationPolarity, staticIndicatorDrive, blankingOutput_n;
  logic [1:0] bresp, rresp;
  driveLevel_t columnDriverOutputs, rowDriverOutputs;
  note_t rdQ[$];
  logic [1:0] wrQ[$];
  int mismatches = 0, n_tests = 0, cycles = 0, gap;
  integer seed = 32'h2c6ab177;
  wire [8:0] pins = {rowShiftPulse, alternationPolarity, staticIndicatorDrive, blankingOutput_n,
    regResistorOn, columnDriverOutputs, rowDriverOutputs};

  always #2 clk = ~clk;
  lcd_host_model lcd_host_model_inst (.clk(clk), .holdClear(holdClear), .chipClear_n(chipClear_n));
  lcd_reset_defaults lcd_reset_defaults_inst (.clk, .reset_n, .chipClear_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .rowShiftPulse, .alternationPolarity, .staticIndicatorDrive,
    .blankingOutput_n, .columnDriverOutputs, .rowDriverOutputs, .regResistorOn);
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic pinCheck(input logic [8:0] exp, input logic [8:0] m);
    @(negedge clk);
    check({25'h0, pins & m}, {25'h0, exp});
  endtask : pinCheck
  // Address and data are offered together and each released once taken
  task automatic axiWrite(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er = 2'h0);
    logic awDone, wDone;
    @(posedge clk);
    wrQ.push_back(er);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    awDone = 1'b0; wDone = 1'b0;
    do begin
      @(posedge clk);
      if (!awDone && awready) begin awDone = 1'b1; awvalid <= 1'b0; end
      if (!wDone && wready) begin wDone = 1'b1; wvalid <= 1'b0; end
    end while (!(awDone && wDone));
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] er = 2'h0);
    @(posedge clk);
    rdQ.push_back('{{er, e}, {2'h3, m}});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask : axiRead
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin : monitor
    note_t n;
    if (rvalid && rready) begin
      n = rdQ.pop_front();
      check({rresp, rdata} & n.m, n.e);
    end
    if (bvalid && bready) check({32'h0, bresp}, {32'h0, wrQ.pop_front()});
  end
  // Whole run is well under a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    pinCheck(9'h1f0, 9'h1ff);
    axiRead(`OFS_STATUS, 32'h0f0, 32'h1f0);
    @(posedge clk) holdClear <= 1'b0;
    repeat (3) @(posedge clk);
    pinCheck(9'h005, 9'h17f);
    axiRead(`OFS_STATUS, 32'h0f0, 32'h1f0);
    axiWrite(`OFS_POWER, 32'h7, 4'hf);
    repeat (14) @(posedge clk);
    axiRead(`OFS_POWER, 32'h0, 32'h7);
    axiRead(`OFS_STATUS, 32'h060, 32'h1f0);
    $display("test power-up done");
    v = $random(seed);
    axiWrite(`OFS_CTRL, 32'h7f, 4'hf);
    axiWrite(`OFS_POWER, 32'h7, 4'hf);
    axiWrite(`OFS_ADDR, {9'h0, v[14:8], 16'h052a}, 4'hf);
    axiWrite(`OFS_VOLUME, {14'h0, 2'h3, 6'h0, 2'h3, 2'h0, v[21:16]}, 4'hf);
    pinCheck(9'h040, 9'h040);
    axiRead(`OFS_ADDR, {9'h0, v[14:8], 16'h052a}, 32'h00ff0f3f);
    axiWrite(`OFS_CTRL, 32'h8000007f, 4'hf);
    axiWrite(`OFS_POWER, 32'h0, 4'hf);
    repeat (14) @(posedge clk);
    axiRead(`OFS_CTRL, 32'h0f, 32'h7f);
    axiRead(`OFS_POWER, 32'h7, 32'h7);
    axiRead(`OFS_ADDR, 32'h0, 32'h00ff0f3f);
    axiRead(`OFS_VOLUME, {26'h0, `VOLUME_DEFAULT}, 32'h3033f);
    pinCheck(9'h025, 9'h07f);
    $display("test soft reset done");
    for (int i = 0; i < 3; i++) axiWrite(`OFS_SERIAL, {31'h0, !i[0]}, 4'h1);
    axiRead(`OFS_SERIAL, 32'h305, 32'h7ff);
    axiWrite(`OFS_CTRL, 32'h08, 4'hf);
    axiRead(`OFS_STATUS, 32'h160, 32'h1f0);
    @(posedge clk) holdClear <= 1'b1;
    repeat (3) @(posedge clk);
    axiRead(`OFS_SERIAL, 32'h0, 32'h7ff);
    @(posedge clk) holdClear <= 1'b0;
    repeat (16) @(posedge clk);
    axiRead(`OFS_CTRL, 32'h0, 32'h7f);
    axiRead(`OFS_POWER, 32'h0, 32'h7);
    axiRead(`OFS_STATUS, 32'h060, 32'h1f0);
    $display("test hard clear done");
    axiWrite(`OFS_ADDR, 32'h00820000, 4'hf);
    axiWrite(`OFS_CTRL, 32'h20, 4'hf);
    repeat (2) axiRead(`OFS_DATA, 32'h82, 32'hff);
    axiWrite(`OFS_CTRL, 32'h80000000, 4'hf);
    repeat (14) @(posedge clk);
    axiRead(`OFS_DATA, 32'h0, 32'hff);
    axiRead(`OFS_DATA, 32'h1, 32'hff);
    axiWrite(`OFS_ADDR, 32'h00830000, 4'hf);
    repeat (2) axiRead(`OFS_DATA, 32'h83, 32'hff);
    $display("test column done");
    axiRead(6'h1c, 32'h0, 32'hffffffff, 2'h2);
    axiWrite(6'h1c, 32'h1, 4'hf, 2'h2);
    axiWrite(`OFS_STATUS, 32'hff, 4'hf);
    do @(posedge clk); while (!rowShiftPulse);
    gap = 0;
    do begin @(posedge clk); gap++; end while (!rowShiftPulse && gap < 600);
    check(34'(gap), 34'(`LINE_DIV_CYC));
    $display("test bus and timing done");
    finish_test();
  end
endmodule : lcd_reset_defaults_test
